//--- dgp_port.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
// Contract
// - first port output values sit in a five-bit latch, one bit per pin
// - first port pin four is Schmitt input, open-drain, and timer clock
// - first port direction 1 floats the pin, 0 drives the latch out
// - first port data read returns pin levels; write updates latch only
// - port set and clear writes are read-modify-write from sampled pin levels
// - first port pins used as comparator inputs read back as zero
// - reset: first port inputs, digital inputs off, comparator grounded
// - direction bits still rule comparator input pins; keep them inputs
// - comparator outputs on pins three and four need direction cleared
// - every second port pin has a software-enabled weak pull-up
// - second port pins four to seven interrupt on input change
// - second port pin zero is external interrupt, Schmitt when enabled
// - second port pins six and seven go Schmitt in serial programming
// - second direction and option reset to ones; data latch to zero
// - a pin serving an enabled peripheral is not general purpose I/O
module dgp_port
    import dgp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [4:0] first_port_pin_in,
    output logic [4:0] first_port_pin_out,
    output logic [4:0] first_port_pin_oe,
    output logic [4:0] first_port_digital_in_en,
    output logic comparator_inputs_grounded,
    output logic [2:0] comparator_mode,
    input wire logic [1:0] comparator_result,
    output logic [7:0] voltage_ref_control,
    output logic timer_external_clock_in,
    output logic [5:0] timer_option,
    input wire logic [7:0] second_port_pin_in,
    output logic [7:0] second_port_pin_out,
    output logic [7:0] second_port_pin_oe,
    output logic [7:0] second_port_pullup_en,
    output logic [7:0] second_port_schmitt_sel,
    input wire logic serial_prog_mode_in,
    output logic irq
);
    logic [4:0] dir1;
    logic [4:0] lat1;
    logic [7:0] dir2;
    logic [7:0] lat2;
    logic [7:0] opt;
    logic [2:0] cmp_mode;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [1:0] rd_snap;
    logic [13:0] raw_in;
    logic [13:0] filt;
    logic [13:0] filt_q;
    logic [3:0] change_ref;
    logic [4:0] analog;
    logic [4:0] p1_read;
    logic [7:0] p2_read;
    logic cmp_out_mode;
    logic [7:0] idx;
    logic addr_ok;
    logic setup;
    logic access;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic [7:0] wbyte;
    logic [31:0] next_rdata;
    logic [1:0] events;
    logic [4:0] next_out1;
    logic [4:0] next_oe1;
    logic serial_prog;
    logic [2:0] warm;
    logic primed;

    assign raw_in = {serial_prog_mode_in, second_port_pin_in,
                     first_port_pin_in};

    // three stages; a change counts only once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < 14; g++) begin : g_sync
            logic [SYNC_STAGES-1:0] sh;
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    sh <= '0;
                    filt[g] <= 1'b0;
                end else begin
                    sh <= {sh[SYNC_STAGES-2:0], raw_in[g]};
                    if (sh[1] == sh[2]) begin
                        filt[g] <= sh[2];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            filt_q <= '0;
        end else begin
            filt_q <= filt;
        end
    end

    assign serial_prog = filt[13];

    // the filter leaves reset at zero whatever the pins show; until it has
    // filled, edge and change detection stay off so no false event follows
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            warm <= '0;
        end else if (!primed) begin
            warm <= warm + 3'h1;
        end
    end

    assign primed = (warm == SYNC_WARM_CYCLES);

    // bus decode; the bus always answers in the access cycle
    assign idx = paddr[9:2];
    assign addr_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_acc = access && pwrite && !pslverr;
    assign rd_acc = access && !pwrite && !pslverr;
    assign pready = access;
    assign wbyte = pwdata[7:0];

    always_comb begin
        case (cmp_mode)
            CMP_MODE_OFF: analog = ANALOG_MASK_OFF;
            CMP_MODE_OUTPUTS: analog = ANALOG_MASK_OUT;
            default: analog = ANALOG_MASK_ALL;
        endcase
    end

    assign cmp_out_mode = (cmp_mode == CMP_MODE_OUTPUTS);
    // analog pins read zero and pin four stays a digital Schmitt input
    assign p1_read = filt[4:0] & ~analog;
    assign p2_read = filt[12:5];

    always_comb begin
        mapped = 1'b1;
        next_rdata = '0;
        case (idx)
            IDX_FIRST_PORT_DATA: next_rdata[4:0] = p1_read;
            IDX_FIRST_PORT_DIRECTION: next_rdata[4:0] = dir1;
            IDX_SECOND_PORT_DATA: next_rdata[7:0] = p2_read;
            IDX_SECOND_PORT_DIRECTION: next_rdata[7:0] = dir2;
            IDX_OPTION_CONFIG: next_rdata[7:0] = opt;
            IDX_COMPARATOR_CONTROL: next_rdata[2:0] = cmp_mode;
            IDX_VOLTAGE_REF_CONTROL: next_rdata[7:0] = voltage_ref_control;
            IDX_IRQ_STATUS: next_rdata[1:0] = irq_status;
            IDX_IRQ_MASK: next_rdata[1:0] = irq_mask;
            IDX_FIRST_PORT_SET, IDX_FIRST_PORT_CLEAR,
            IDX_SECOND_PORT_SET, IDX_SECOND_PORT_CLEAR: next_rdata = '0;
            default: mapped = 1'b0;
        endcase
        if (!addr_ok) begin
            mapped = 1'b0;
            next_rdata = '0;
        end
    end

    // read data is caught in the setup cycle so the access cycle sees a flop
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= '0;
            pslverr <= 1'b0;
            rd_snap <= '0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= !mapped;
            rd_snap <= (!pwrite && mapped && idx == IDX_IRQ_STATUS) ?
                       irq_status : 2'b00;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dir1 <= FIRST_DIR_RST;
            cmp_mode <= CMP_MODE_RST;
            voltage_ref_control <= VREF_RST;
            irq_mask <= IRQ_MASK_RST;
        end else if (wr_acc) begin
            case (idx)
                IDX_FIRST_PORT_DIRECTION: dir1 <= wbyte[4:0];
                IDX_COMPARATOR_CONTROL: cmp_mode <= wbyte[2:0];
                IDX_VOLTAGE_REF_CONTROL: voltage_ref_control <= wbyte;
                IDX_IRQ_MASK: irq_mask <= wbyte[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dir2 <= SECOND_DIR_RST;
            opt <= OPTION_RST;
        end else if (wr_acc) begin
            case (idx)
                IDX_SECOND_PORT_DIRECTION: dir2 <= wbyte;
                IDX_OPTION_CONFIG: opt <= wbyte;
                default: ;
            endcase
        end
    end

    // set and clear aliases modify the sampled pin levels, as a bit op would
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lat1 <= FIRST_DATA_RST;
            lat2 <= SECOND_DATA_RST;
        end else if (wr_acc) begin
            case (idx)
                IDX_FIRST_PORT_DATA: lat1 <= wbyte[4:0];
                IDX_FIRST_PORT_SET: lat1 <= p1_read | wbyte[4:0];
                IDX_FIRST_PORT_CLEAR: lat1 <= p1_read & ~wbyte[4:0];
                IDX_SECOND_PORT_DATA: lat2 <= wbyte;
                IDX_SECOND_PORT_SET: lat2 <= p2_read | wbyte;
                IDX_SECOND_PORT_CLEAR: lat2 <= p2_read & ~wbyte;
                default: ;
            endcase
        end
    end

    // comparator outputs take pins three and four from the latch
    always_comb begin
        next_out1 = lat1;
        if (cmp_out_mode) begin
            next_out1[3] = comparator_result[0];
            next_out1[4] = comparator_result[1];
        end
        next_oe1 = ~dir1;
        next_oe1[4] = !dir1[4] && !next_out1[4];
        next_out1[4] = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            first_port_pin_out <= '0;
            first_port_pin_oe <= '0;
            second_port_pin_out <= '0;
            second_port_pin_oe <= '0;
        end else begin
            first_port_pin_out <= next_out1;
            first_port_pin_oe <= next_oe1;
            second_port_pin_out <= lat2;
            second_port_pin_oe <= ~dir2;
        end
    end

    // pull-ups only where the pin is an input; a driven pin needs none
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            second_port_pullup_en <= '0;
            second_port_schmitt_sel <= '0;
            first_port_digital_in_en <= '0;
            comparator_inputs_grounded <= 1'b1;
            timer_external_clock_in <= 1'b0;
        end else begin
            second_port_pullup_en <= opt[OPT_PULLUP_DISABLE_BIT] ? 8'h00 :
                                     dir2;
            second_port_schmitt_sel <= {{2{serial_prog}}, 5'h00,
                                        irq_mask[IRQ_EXT_BIT]};
            first_port_digital_in_en <= ~analog;
            comparator_inputs_grounded <= (cmp_mode == CMP_MODE_RST);
            timer_external_clock_in <= filt[4];
        end
    end

    assign comparator_mode = cmp_mode;
    assign timer_option = opt[5:0];

    // change reference is refreshed by each read of the second port
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            change_ref <= '0;
        end else if (!primed ||
                     (rd_acc && idx == IDX_SECOND_PORT_DATA)) begin
            change_ref <= filt[12:9];
        end
    end

    assign events[IRQ_CHANGE_BIT] = primed && (|((filt[12:9] ^ change_ref)
                                      & dir2[7:4]));
    assign events[IRQ_EXT_BIT] = primed && (opt[OPT_INTERRUPT_EDGE_SELECT] ?
                                 (filt[5] && !filt_q[5]) :
                                 (!filt[5] && filt_q[5]));

    // read clears only what the read reported, so a new event is kept
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~(rd_acc ? rd_snap : 2'b00))
                          | events;
        end
    end

    assign irq = |(irq_status & irq_mask);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    AST_P1_DIR_HIZ: assert property (
        (first_port_pin_oe & $past(dir1)) == 5'h00)
        else $error("first port drives a pin set as input");
    AST_P4_OPEN_DRAIN: assert property (
        first_port_pin_out[4] == 1'b0 &&
        (first_port_pin_oe[4] -> !$past(dir1[4]) &&
         ($past(cmp_out_mode) ? !$past(comparator_result[1]) :
          !$past(lat1[4]))))
        else $error("pin four drove high");
    AST_CMP_READ_ZERO: assert property (
        setup && !pwrite && idx == IDX_FIRST_PORT_DATA && addr_ok &&
        cmp_mode != CMP_MODE_OFF |=> prdata[2:0] == 3'h0)
        else $error("comparator input pin read nonzero");
    AST_RESET_STATE: assert property (
        $rose(rst_b) |-> dir1 == FIRST_DIR_RST && comparator_inputs_grounded
        && first_port_digital_in_en == 5'h00)
        else $error("first port not in reset state");
    AST_RMW_SET: assert property (
        wr_acc && idx == IDX_FIRST_PORT_SET |=>
        lat1 == ($past(p1_read) | $past(wbyte[4:0])))
        else $error("set alias did not modify sampled pins");
    AST_PULLUP_OFF: assert property (
        opt[OPT_PULLUP_DISABLE_BIT] |=> second_port_pullup_en == 8'h00)
        else $error("pull-up on while disabled");
    AST_IOC_SET: assert property (
        primed && dir2[7] && filt[12] != change_ref[3] |=>
        irq_status[IRQ_CHANGE_BIT])
        else $error("change on pin seven not flagged");
    AST_EXT_RISE: assert property (
        primed && opt[OPT_INTERRUPT_EDGE_SELECT] && $rose(filt[5]) |=>
        irq_status[IRQ_EXT_BIT] && (irq_mask[IRQ_EXT_BIT] -> irq))
        else $error("rising edge on pin zero not flagged");
    AST_P2_DIR_HIZ: assert property (
        (second_port_pin_oe & $past(dir2)) == 8'h00)
        else $error("second port drives a pin set as input");
    AST_OPT_RESET: assert property (
        $rose(rst_b) |-> opt == OPTION_RST && dir2 == SECOND_DIR_RST)
        else $error("second port reset values wrong");
    AST_SET_WINS: assert property (
        rd_acc && events[IRQ_EXT_BIT] |=> irq_status[IRQ_EXT_BIT])
        else $error("event lost on status read");
    AST_PROG_SCHMITT: assert property (
        serial_prog |=> second_port_schmitt_sel[7:6] == 2'b11)
        else $error("programming pins not on Schmitt inputs");
    AST_WRITE_LATCH: assert property (
        wr_acc && idx == IDX_FIRST_PORT_DATA |=> lat1 == $past(wbyte[4:0]))
        else $error("first port latch missed a write");
    AST_CMP_OUT_PIN: assert property (
        cmp_out_mode |=> first_port_pin_out[3] == $past(comparator_result[0]))
        else $error("comparator output not on pin three");
    AST_ERR_NO_WRITE: assert property (
        access && pwrite && pslverr |=> $stable(dir1) && $stable(dir2))
        else $error("refused write changed a register");

    COV_RMW_CLEAR: cover property (wr_acc && idx == IDX_FIRST_PORT_CLEAR);
    COV_IRQ_CHANGE: cover property (irq && irq_status[IRQ_CHANGE_BIT]);
    COV_CMP_OUT: cover property (cmp_out_mode && first_port_pin_oe[3]);
    COV_UNMAPPED: cover property (access && pslverr);
    COV_PULLUP_ON: cover property (second_port_pullup_en != 8'h00);
endmodule

//--- dgp_pkg.sv
package dgp_pkg;
    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_SECOND_PORT_DATA = 8'h06;
    localparam logic [7:0] IDX_OPTION_CONFIG = 8'h81;
    localparam logic [7:0] IDX_SECOND_PORT_DIRECTION = 8'h86;
    localparam logic [7:0] IDX_FIRST_PORT_DATA = 8'h05;
    localparam logic [7:0] IDX_FIRST_PORT_DIRECTION = 8'h85;
    localparam logic [7:0] IDX_COMPARATOR_CONTROL = 8'h1F;
    localparam logic [7:0] IDX_VOLTAGE_REF_CONTROL = 8'h9F;
    localparam logic [7:0] IDX_FIRST_PORT_SET = 8'h10;
    localparam logic [7:0] IDX_FIRST_PORT_CLEAR = 8'h11;
    localparam logic [7:0] IDX_SECOND_PORT_SET = 8'h12;
    localparam logic [7:0] IDX_SECOND_PORT_CLEAR = 8'h13;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h14;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h15;

    // reset values
    localparam logic [4:0] FIRST_DIR_RST = 5'h1F;
    localparam logic [4:0] FIRST_DATA_RST = 5'h00;
    localparam logic [7:0] SECOND_DIR_RST = 8'hFF;
    localparam logic [7:0] SECOND_DATA_RST = 8'h00;
    localparam logic [7:0] OPTION_RST = 8'hFF;
    localparam logic [2:0] CMP_MODE_RST = 3'h0;
    localparam logic [7:0] VREF_RST = 8'h00;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;

    // option_config fields
    localparam int OPT_PULLUP_DISABLE_BIT = 7;
    localparam int OPT_INTERRUPT_EDGE_SELECT = 6;

    // comparator_control mode field values
    localparam logic [2:0] CMP_MODE_OUTPUTS = 3'h6;
    localparam logic [2:0] CMP_MODE_OFF = 3'h7;
    localparam logic [4:0] ANALOG_MASK_ALL = 5'h0F;
    localparam logic [4:0] ANALOG_MASK_OUT = 5'h07;
    localparam logic [4:0] ANALOG_MASK_OFF = 5'h00;

    // interrupt status bit positions
    localparam int IRQ_EXT_BIT = 0;
    localparam int IRQ_CHANGE_BIT = 1;

    localparam int SYNC_STAGES = 3;
    // edges after reset until filter and edge history both hold pin levels
    localparam logic [2:0] SYNC_WARM_CYCLES = 3'h5;
endpackage

//--- dgp_board.sv
`timescale 1ns/1ps
module dgp_board (
    input wire logic sys_clk,
    input wire logic [4:0] a_out,
    input wire logic [4:0] a_oe,
    input wire logic [4:0] a_ext,
    input wire logic [4:0] a_en,
    input wire logic [7:0] b_out,
    input wire logic [7:0] b_oe,
    input wire logic [7:0] b_pu,
    input wire logic [7:0] b_ext,
    input wire logic [7:0] b_en,
    output logic [4:0] a_pin,
    output logic [7:0] b_pin
);
    logic [4:0] a_last;
    logic [7:0] b_last;
    always_ff @(posedge sys_clk) begin
        a_last <= a_pin;
        b_last <= b_pin;
    end
    // a released line with no pull keeps flipping so it never reads stable
    // pin four out is always low, so its enable alone pulls it down
    always_comb begin
        a_pin = (a_oe & a_out) | (~a_oe & a_en & a_ext)
            | (~a_oe & ~a_en & ~a_last);
        b_pin = (b_oe & b_out) | (~b_oe & b_en & b_ext)
            | (~b_oe & ~b_en & (b_pu | ~b_last));
    end
endmodule

//--- tb_dual_gpio_port.sv
`timescale 1ns/1ps
module tb_dual_gpio_port;
    import dgp_pkg::*;
    logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic irq, tclk, grounded, sp_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] a_in, a_out, a_oe, a_den, a_ext, a_en;
    logic [2:0] cmode;
    logic [1:0] cres;
    logic [5:0] topt;
    logic [7:0] vref, b_in, b_out, b_oe, b_pu, b_st, b_ext, b_en;
    int num_errors = 0;
    int comparisons = 0;
    logic [2:0] modes [3] = '{3'h0, 3'h6, 3'h7};
    logic [4:0] mode_rd [3] = '{5'h10, 5'h18, 5'h1F};

    dgp_port u_dgp_port (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .first_port_pin_in(a_in),
        .first_port_pin_out(a_out), .first_port_pin_oe(a_oe),
        .first_port_digital_in_en(a_den),
        .comparator_inputs_grounded(grounded), .comparator_mode(cmode),
        .comparator_result(cres), .voltage_ref_control(vref),
        .timer_external_clock_in(tclk), .timer_option(topt),
        .second_port_pin_in(b_in), .second_port_pin_out(b_out),
        .second_port_pin_oe(b_oe), .second_port_pullup_en(b_pu),
        .second_port_schmitt_sel(b_st), .serial_prog_mode_in(sp_mode),
        .irq(irq));
    dgp_board u_dgp_board (.sys_clk(sys_clk), .a_out(a_out), .a_oe(a_oe),
        .a_ext(a_ext), .a_en(a_en), .b_out(b_out), .b_oe(b_oe),
        .b_pu(b_pu), .b_ext(b_ext), .b_en(b_en), .a_pin(a_in),
        .b_pin(b_in));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        xfer(1'b1, idx, wd);
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end

    initial begin
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; rst_b = 1'b0; sp_mode = 1'b0; cres = 2'h0;
        a_ext = 5'h1F; a_en = 5'h1F; b_ext = 8'h00; b_en = 8'hFF;
        cyc(20);
        chk({grounded, a_den, a_oe, b_oe}, 32'h40000);
        rst_b <= 1'b1;
        rchk(IDX_FIRST_PORT_DIRECTION, 32'h1F);
        rchk(IDX_SECOND_PORT_DIRECTION, 32'hFF);
        rchk(IDX_OPTION_CONFIG, 32'hFF);
        rchk(IDX_IRQ_MASK, 32'h0);
        wr(8'h30, 32'h1F);
        chk(err, 32'h1);
        xfer(1'b0, 8'h30, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        for (int i = 0; i < 3; i++) begin
            wr(IDX_COMPARATOR_CONTROL, modes[i]);
            cyc(6);
            rchk(IDX_FIRST_PORT_DATA, mode_rd[i]);
        end
        chk({grounded, a_den}, 32'h1F);
        wr(IDX_FIRST_PORT_DIRECTION, 32'h0);
        wr(IDX_FIRST_PORT_DATA, 32'h15);
        cyc(2);
        chk({a_out, a_oe}, {5'h05, 5'h0F});
        cyc(6);
        rchk(IDX_FIRST_PORT_DATA, 32'h15);
        a_ext <= 5'h0A;
        wr(IDX_FIRST_PORT_DIRECTION, 32'h1F);
        cyc(6);
        rchk(IDX_FIRST_PORT_DATA, 32'h0A);
        chk({a_out, a_oe, tclk}, {5'h05, 5'h00, 1'b0});
        // set and clear aliases start from the pins, not the latch
        wr(IDX_FIRST_PORT_SET, 32'h01);
        cyc(2);
        chk(a_out, 32'h0B);
        wr(IDX_FIRST_PORT_DIRECTION, 32'h0);
        cyc(6);
        wr(IDX_FIRST_PORT_CLEAR, 32'h02);
        cyc(2);
        chk({a_out, a_oe}, {5'h09, 5'h1F});
        wr(IDX_COMPARATOR_CONTROL, 32'h6);
        cres <= 2'b01;
        cyc(3);
        chk({a_out[3], a_oe[4]}, 32'h3);
        cres <= 2'b10;
        cyc(3);
        chk({a_out[3], a_oe[4]}, 32'h0);
        wr(IDX_COMPARATOR_CONTROL, 32'h7);
        wr(IDX_FIRST_PORT_DIRECTION, 32'h1F);
        wr(IDX_VOLTAGE_REF_CONTROL, 32'hA5);
        cyc(2);
        chk(vref, 32'hA5);
        wr(IDX_SECOND_PORT_DIRECTION, 32'h0F);
        wr(IDX_SECOND_PORT_DATA, 32'hA5);
        wr(IDX_OPTION_CONFIG, 32'h7F);
        b_ext <= 8'h50;
        cyc(6);
        chk({b_out, b_oe, b_pu}, 24'hA5F00F);
        chk(topt, 32'h3F);
        rchk(IDX_SECOND_PORT_DATA, 32'hA0);
        b_en <= 8'hF0;
        cyc(6);
        rchk(IDX_SECOND_PORT_DATA, 32'hAF);
        b_en <= 8'hFF;
        wr(IDX_OPTION_CONFIG, 32'hFF);
        cyc(2);
        chk(b_pu, 32'h0);
        wr(IDX_SECOND_PORT_DIRECTION, 32'hFF);
        wr(IDX_IRQ_MASK, 32'h3);
        cyc(6);
        chk(b_st[0], 32'h1);
        xfer(1'b0, IDX_SECOND_PORT_DATA, 32'h0);
        xfer(1'b0, IDX_IRQ_STATUS, 32'h0);
        b_ext <= 8'h51;
        cyc(6);
        chk(irq, 32'h1);
        rchk(IDX_IRQ_STATUS, 32'h1);
        cyc(1);
        chk(irq, 32'h0);
        b_ext <= 8'hD1;
        cyc(6);
        chk(irq, 32'h1);
        xfer(1'b0, IDX_SECOND_PORT_DATA, 32'h0);
        rchk(IDX_IRQ_STATUS, 32'h2);
        b_ext <= 8'hD9;
        cyc(6);
        chk(irq, 32'h0);
        wr(IDX_IRQ_MASK, 32'h0);
        b_ext <= 8'h59;
        cyc(6);
        chk(irq, 32'h0);
        wr(IDX_IRQ_MASK, 32'h2);
        cyc(1);
        chk(irq, 32'h1);
        sp_mode <= 1'b1;
        wr(IDX_IRQ_MASK, 32'h0);
        cyc(6);
        chk(b_st, 32'hC0);
        wr(IDX_SECOND_PORT_DIRECTION, 32'h0);
        wr(IDX_OPTION_CONFIG, 32'h0);
        rst_b <= 1'b0;
        cyc(20);
        rst_b <= 1'b1;
        rchk(IDX_SECOND_PORT_DIRECTION, 32'hFF);
        rchk(IDX_OPTION_CONFIG, 32'hFF);
        rchk(IDX_FIRST_PORT_DIRECTION, 32'h1F);
        chk(grounded, 32'h1);
        wrap_up();
    end
endmodule
